// ---- sdtr_pkg.sv ----
// constants, command codes and register map of the dram cycle timing block
package sdtr_pkg;

    // clocking of the block
    localparam int PCLK_PERIOD_PS      = 50000;              // 20 mhz register clock

    // write leveling feedback: longest times, rounded down, at least one cycle
    localparam int LEVEL_FB_PS         = 9000;               // 9 ns standard grades
    localparam int LEVEL_FB_FAST_PS    = 7500;               // 7.5 ns fastest grade
    localparam int LEVEL_FB_CYC_RAW    = LEVEL_FB_PS / PCLK_PERIOD_PS;
    localparam int LEVEL_FB_FAST_RAW   = LEVEL_FB_FAST_PS / PCLK_PERIOD_PS;
    localparam int LEVEL_FB_CYC        = (LEVEL_FB_CYC_RAW < 1) ? 1 : LEVEL_FB_CYC_RAW;
    localparam int LEVEL_FB_FAST_CYC   = (LEVEL_FB_FAST_RAW < 1) ? 1 : LEVEL_FB_FAST_RAW;

    // link side timing, in picoseconds and link clock cycles
    localparam logic [17:0] ROW_ACTIVE_MIN_PS  = 18'h088B8;  // 35 ns default row active time
    localparam logic [15:0] WRITE_RECOVERY_PS  = 16'h3A98;   // 15 ns
    localparam logic [2:0]  WR_MIN_CK          = 3'h4;       // 4 ck floor with delay loop off
    localparam logic [5:0]  WR_START_FULL      = 6'h04;      // eight beat or on-the-fly chop
    localparam logic [5:0]  WR_START_CHOP      = 6'h02;      // chop fixed by mode register
    localparam logic [2:0]  WIN_LEN_FULL       = 3'h4;       // strobe window ck, eight beats
    localparam logic [2:0]  WIN_LEN_CHOP       = 3'h2;       // strobe window ck, four beats

    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LAT    = 8'h04;
    localparam logic [7:0] ADDR_TCK    = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    // field positions
    localparam int CTRL_LEVEL_EN  = 0;
    localparam int CTRL_DELAY_LOOP_DISABLED   = 1;
    localparam int CTRL_FAST      = 2;
    localparam int CTRL_CHOP_FIX  = 3;
    localparam int LAT_CL_LSB     = 0;
    localparam int LAT_AL_LSB     = 8;
    localparam int LAT_WL_LSB     = 16;
    localparam int STAT_PEND_LSB  = 8;
    localparam int STAT_WR_BUSY   = 16;
    localparam int STAT_LEVEL_FB  = 17;

    // reset values
    localparam logic [3:0]  CTRL_RESET = 4'h0;
    localparam logic [4:0]  CL_RESET   = 5'h06;
    localparam logic [4:0]  AL_RESET   = 5'h00;
    localparam logic [4:0]  WL_RESET   = 5'h05;
    localparam logic [15:0] TCK_RESET  = 16'h09C4;           // 2500 ps link period

    // command codes on the command pins
    typedef enum logic [2:0] {
        SDTR_NOP = 3'h0, SDTR_ACT = 3'h1, SDTR_RD = 3'h2, SDTR_RDA = 3'h3,
        SDTR_WR  = 3'h4, SDTR_WRA = 3'h5, SDTR_PRE = 3'h6, SDTR_MRW = 3'h7
    } sdtr_cmd_t;

endpackage : sdtr_pkg

// ---- sdtr_timing.sv ----
// dram side timing engine: leveling feedback, read strobe window, auto precharge, write recovery
`timescale 1ns/1ps
`default_nettype none
module sdtr_timing
    import sdtr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        ck,
    input  wire logic [2:0]  cmd_pin,
    input  wire logic [2:0]  bank_pin,
    input  wire logic        otf_chop_pin,
    input  wire logic        dqs_pin,
    output logic             dq0_o,
    output logic             dq0_oe,
    output logic             read_strobe_window,
    output logic             wr_recovery_start,
    output logic [7:0]       precharge_done
);
    import sdtr_pkg::*;

    typedef struct packed {
        logic [2:0]        ck_sy;        // [0] first stage, [2] previous level
        logic [1:0]        dqs_sy;
        logic              dqs_prev;
        logic [2:0]        cmd_s1, cmd_s2, bank_s1, bank_s2;
        logic              chop_s1, chop_s2;
        logic [3:0]        ctrl;
        logic [4:0]        cl, al, wl;
        logic [15:0]       tck;
        logic [31:0]       rdata;
        logic              slverr;
        logic              fb_val, fb_oe;
        logic [5:0]        rd_wait;
        logic              rd_armed, rd_chop;
        logic [2:0]        win_len;
        logic [5:0]        wr_wait;
        logic              wr_armed, wr_busy, wr_start;
        logic [15:0]       wr_acc;
        logic [2:0]        wr_cnt;
        logic [7:0]        act, pend, pend_wr, pre_done;
        logic [7:0][17:0]  ras_acc;
    } sdtr_state_t;

    sdtr_state_t q, d;
    logic        ck_rise, dqs_rise, wr_ok, unmapped;
    logic [7:0]  ras_met;
    logic [5:0]  rd_lat;

    // address decode, used by the write decode and the error answer
    function automatic logic sdtr_mapped(input logic [7:0] a);
        sdtr_mapped = (a == ADDR_CTRL) || (a == ADDR_LAT) || (a == ADDR_TCK) || (a == ADDR_STATUS);
    endfunction

    // edge finders on the synchronised link pins, never on the first stage
    assign ck_rise  = q.ck_sy[1] & ~q.ck_sy[2];
    assign dqs_rise = q.dqs_sy[1] & ~q.dqs_prev;
    assign unmapped = ~sdtr_mapped(paddr);
    assign wr_ok    = ~q.wr_busy & ~q.wr_armed;

    // read strobe window start: one ck earlier with the delay loop off
    assign rd_lat = q.ctrl[CTRL_DELAY_LOOP_DISABLED] ? 6'({1'b0, q.cl} + {1'b0, q.al} - 6'h01)
                                         : 6'({1'b0, q.cl} + {1'b0, q.al});

    // row active time met per bank, elapsed ps against the picosecond limit
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            ras_met[b] = (q.ras_acc[b] >= ROW_ACTIVE_MIN_PS);
        end
    end

    // next state of the whole block
    always_comb begin
        logic [18:0] rsum;
        logic [16:0] wsum;
        logic        is_rd, is_wr;
        logic [2:0]  bk;
        rsum  = 19'h00000;
        wsum  = 17'h00000;
        d     = q;
        bk    = q.bank_s2;
        is_rd = ck_rise && ((q.cmd_s2 == SDTR_RD) || (q.cmd_s2 == SDTR_RDA));
        is_wr = ck_rise && ((q.cmd_s2 == SDTR_WR) || (q.cmd_s2 == SDTR_WRA));
        // two-flop synchronisers for every pin from the link
        d.ck_sy    = {q.ck_sy[1], q.ck_sy[0], ck};
        d.dqs_sy   = {q.dqs_sy[0], dqs_pin};
        d.dqs_prev = q.dqs_sy[1];
        d.cmd_s1   = cmd_pin;
        d.cmd_s2   = q.cmd_s1;
        d.bank_s1  = bank_pin;
        d.bank_s2  = q.bank_s1;
        d.chop_s1  = otf_chop_pin;
        d.chop_s2  = q.chop_s1;
        d.pre_done = 8'h00;
        d.wr_start = 1'b0;

        // apb: read data and error prepared in the setup cycle
        if (psel && !penable) begin
            d.slverr = unmapped;
            case (paddr)
                ADDR_CTRL:   d.rdata = {28'h0000000, q.ctrl};
                ADDR_LAT:    d.rdata = {11'h000, q.wl, 3'h0, q.al, 3'h0, q.cl};
                ADDR_TCK:    d.rdata = {16'h0000, q.tck};
                ADDR_STATUS: d.rdata = {14'h0000, q.fb_val, q.wr_busy, q.pend, q.act};
                default:     d.rdata = 32'h00000000;
            endcase
        end
        if (psel && penable && pwrite && !unmapped) begin
            case (paddr)
                ADDR_CTRL: d.ctrl = pwdata[3:0];
                ADDR_LAT: begin
                    d.cl = pwdata[LAT_CL_LSB +: 5];
                    d.al = pwdata[LAT_AL_LSB +: 5];
                    d.wl = pwdata[LAT_WL_LSB +: 5];
                end
                ADDR_TCK:  d.tck = pwdata[15:0];
                default:   d.tck = q.tck;
            endcase
        end

        // write leveling: strobe edge samples the link clock onto the data pin
        d.fb_oe = q.ctrl[CTRL_LEVEL_EN];
        if (q.ctrl[CTRL_LEVEL_EN] && dqs_rise) begin
            d.fb_val = q.ck_sy[1];
        end

        // read strobe window countdown in link cycles
        if (ck_rise && q.rd_armed) begin
            d.rd_wait = q.rd_wait - 6'h01;
            if (q.rd_wait == 6'h01) begin
                d.rd_armed = 1'b0;
                d.win_len  = q.rd_chop ? WIN_LEN_CHOP : WIN_LEN_FULL;
            end
        end else if (ck_rise && q.win_len != 3'h0) begin
            d.win_len = q.win_len - 3'h1;
        end
        if (is_rd) begin
            d.rd_chop = q.chop_s2;
            if (rd_lat == 6'h00) begin
                d.win_len = q.chop_s2 ? WIN_LEN_CHOP : WIN_LEN_FULL;
            end else begin
                d.rd_armed = 1'b1;
                d.rd_wait  = rd_lat;
            end
        end

        // write recovery: wait, then accumulate elapsed ps and ck
        if (ck_rise && q.wr_armed) begin
            d.wr_wait = q.wr_wait - 6'h01;
            if (q.wr_wait == 6'h01) begin
                d.wr_armed = 1'b0;
                d.wr_busy  = 1'b1;
                d.wr_start = 1'b1;
                d.wr_acc   = 16'h0000;
                d.wr_cnt   = 3'h0;
            end
        end else if (ck_rise && q.wr_busy) begin
            wsum     = {1'b0, q.wr_acc} + {1'b0, q.tck};
            d.wr_acc = wsum[16] ? 16'hFFFF : wsum[15:0];
            d.wr_cnt = (q.wr_cnt == WR_MIN_CK) ? q.wr_cnt : q.wr_cnt + 3'h1;
            if (d.wr_acc >= WRITE_RECOVERY_PS
                && (!q.ctrl[CTRL_DELAY_LOOP_DISABLED] || d.wr_cnt >= WR_MIN_CK)) begin
                d.wr_busy = 1'b0;
            end
        end
        if (is_wr) begin
            d.wr_armed = 1'b1;
            d.wr_busy  = 1'b0;
            d.wr_wait  = 6'({1'b0, q.wl}
                       + (q.ctrl[CTRL_CHOP_FIX] ? WR_START_CHOP : WR_START_FULL));
        end

        // banks: elapsed ps since activate, auto precharge held until met
        for (int b = 0; b < 8; b++) begin
            if (ck_rise && q.act[b]) begin
                rsum         = {1'b0, q.ras_acc[b]} + {3'h0, q.tck};
                d.ras_acc[b] = rsum[18] ? 18'h3FFFF : rsum[17:0];
            end
            if (q.pend[b] && ras_met[b] && (!q.pend_wr[b] || wr_ok)) begin
                d.act[b]      = 1'b0;
                d.pend[b]     = 1'b0;
                d.pre_done[b] = 1'b1;
            end
        end
        if (ck_rise) begin
            case (sdtr_cmd_t'(q.cmd_s2))
                SDTR_ACT: begin
                    d.act[bk]     = 1'b1;
                    d.ras_acc[bk] = 18'h00000;
                end
                SDTR_RDA, SDTR_WRA: begin
                    d.pend[bk]    = 1'b1;
                    d.pend_wr[bk] = (q.cmd_s2 == SDTR_WRA);
                end
                SDTR_PRE: d.act[bk] = 1'b0;
                default:  d.act = d.act;
            endcase
        end
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q       <= '0;
            q.ctrl  <= CTRL_RESET;
            q.cl    <= CL_RESET;
            q.al    <= AL_RESET;
            q.wl    <= WL_RESET;
            q.tck   <= TCK_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign pready             = 1'b1;
    assign prdata             = q.rdata;
    assign pslverr            = q.slverr;
    assign dq0_o              = q.fb_val;
    assign dq0_oe             = q.fb_oe;
    assign read_strobe_window = (q.win_len != 3'h0);
    assign wr_recovery_start  = q.wr_start;
    assign precharge_done     = q.pre_done;

    // command seen at a detected link clock rise, for the checks below
    logic is_rd_chk, is_wr_chk;
    assign is_rd_chk = ck_rise && (q.cmd_s2 == SDTR_RD || q.cmd_s2 == SDTR_RDA);
    assign is_wr_chk = ck_rise && (q.cmd_s2 == SDTR_WR || q.cmd_s2 == SDTR_WRA);

    // checks
    level_fb_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
        (q.ctrl[CTRL_LEVEL_EN] && dqs_rise) |=> (dq0_o == $past(q.ck_sy[1])) && dq0_oe)
        else $error("leveling feedback not returned in one cycle");
    rd_window_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        (is_rd_chk && q.ctrl[CTRL_DELAY_LOOP_DISABLED] && rd_lat != 6'h00)
            |=> q.rd_armed && (q.rd_wait == 6'($past(q.cl) + $past(q.al) - 5'h01)))
        else $error("read window delay not cas plus additive minus one");
    rd_window_open_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ck_rise && q.rd_armed && q.rd_wait == 6'h01) |=> read_strobe_window)
        else $error("read window did not open at end of delay");
    ras_accumulate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ck_rise && q.act[3] && !q.ras_acc[3][17] && !(q.cmd_s2 == SDTR_ACT && q.bank_s2 == 3'h3))
            |=> q.ras_acc[3] == 18'($past(q.ras_acc[3]) + $past(q.tck)))
        else $error("row active time not accumulated by link period");
    ap_holdoff_a: assert property (@(posedge pclk) disable iff (!presetn)
        (|q.pre_done) |-> ((q.pre_done & ~$past(ras_met)) == 8'h00))
        else $error("auto precharge before row active time");
    wr_start_chop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (is_wr_chk && q.ctrl[CTRL_CHOP_FIX]) |=> q.wr_wait == 6'($past(q.wl) + 5'h02))
        else $error("fixed chop write recovery start not latency plus two");
    wr_start_full_a: assert property (@(posedge pclk) disable iff (!presetn)
        (is_wr_chk && !q.ctrl[CTRL_CHOP_FIX]) |=> q.wr_wait == 6'($past(q.wl) + 5'h04))
        else $error("write recovery start not latency plus four");
    wr_recovery_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(q.wr_busy) && !$past(q.wr_armed) && !q.wr_armed)
            |-> ($past(q.wr_acc) + 16'($past(q.tck)) >= WRITE_RECOVERY_PS || $past(q.wr_acc) == 16'hFFFF
                 || q.wr_acc >= WRITE_RECOVERY_PS))
        else $error("write recovery ended before 15 ns");
    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && unmapped) |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped address not refused");

    rd_window_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(read_strobe_window));
    ap_done_c:   cover property (@(posedge pclk) disable iff (!presetn) |q.pre_done);
    level_c:     cover property (@(posedge pclk) disable iff (!presetn) q.ctrl[CTRL_LEVEL_EN] && dqs_rise);
    wr_rec_c:    cover property (@(posedge pclk) disable iff (!presetn) $fell(q.wr_busy));

endmodule : sdtr_timing
`default_nettype wire

// ---- sdtr_ctrl_model.sv ----
// controller-side model: drives the dram clock, commands and leveling strobes
`timescale 1ns/1ps
`default_nettype none
module sdtr_ctrl_model
    import sdtr_pkg::*;
(
    output logic       ck,
    output logic [2:0] cmd_pin,
    output logic [2:0] bank_pin,
    output logic       otf_chop_pin,
    output logic       dqs_pin,
    output int         rises
);
    int cnt = 0;

    // free running 400 ns clock, phase unrelated to pclk; idle command is nop
    initial begin
        ck = 1'b0;
        cmd_pin = SDTR_NOP;
        bank_pin = 3'h0;
        otf_chop_pin = 1'b0;
        dqs_pin = 1'b0;
        #32;
        forever #200 ck = ~ck;
    end

    // rise counter lets the bench measure latencies in ck
    always @(posedge ck) cnt <= cnt + 1;
    assign rises = cnt;

    // command changes at ck fall so it is stable about the sampling rise
    task automatic issue(input sdtr_cmd_t c, input logic [2:0] b, input logic chop, output int at);
        @(negedge ck);
        cmd_pin = c;
        bank_pin = b;
        otf_chop_pin = chop;
        @(posedge ck);
        #1 at = cnt;
    endtask

    // the command set carries no refresh code, so refresh spacing is not driven here
    // back to nop after the last command
    task automatic idle;
        @(negedge ck);
        cmd_pin = SDTR_NOP;
        otf_chop_pin = 1'b0;
    endtask

    // strobe rise placed in the high or low half of ck, after the enable wait
    task automatic strobe(input int wait_ck, input logic at_high);
        repeat (wait_ck) @(posedge ck);
        if (at_high) @(posedge ck);
        else @(negedge ck);
        #50 dqs_pin = 1'b1;
        #100 dqs_pin = 1'b0;
    endtask
endmodule // sdtr_ctrl_model
`default_nettype wire

// ---- sdtr_timing_tb_top.sv ----
// self-checking bench for the dram cycle timing block
`timescale 1ns/1ps
`default_nettype none
module sdtr_timing_tb_top;
    import sdtr_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, ck, otf_chop_pin, dqs_pin, dq0_o, dq0_oe;
    logic        read_strobe_window, wr_recovery_start;
    logic [2:0]  cmd_pin, bank_pin;
    logic [7:0]  precharge_done;
    int          rises;
    int          n_mismatch = 0;
    int          num_checks = 0;

    always #25 pclk = ~pclk;

    sdtr_timing u_sdtr_timing (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ck(ck), .cmd_pin(cmd_pin), .bank_pin(bank_pin), .otf_chop_pin(otf_chop_pin),
        .dqs_pin(dqs_pin), .dq0_o(dq0_o), .dq0_oe(dq0_oe), .read_strobe_window(read_strobe_window),
        .wr_recovery_start(wr_recovery_start), .precharge_done(precharge_done));
    sdtr_ctrl_model u_sdtr_ctrl_model (.ck(ck), .cmd_pin(cmd_pin), .bank_pin(bank_pin),
        .otf_chop_pin(otf_chop_pin), .dqs_pin(dqs_pin), .rises(rises));

    // prints the counts and the verdict, then ends the run
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // a wait that ran out counts as a mismatch and ends the run
    task automatic stop(input string msg);
        n_mismatch++;
        $display("MISMATCH %0t %s", $time, msg);
        give_verdict();
    endtask

    // single compare for all results, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer: setup, access held until pready, data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) stop("apb timeout");
    endtask

    // selects the observed output for the bounded waits
    function automatic logic sig(input int s, input int b);
        case (s)
            0: return read_strobe_window;
            1: return wr_recovery_start;
            default: return precharge_done[b];
        endcase
    endfunction

    // waits for an output level at falling pclk edges, where outputs are settled; returns the ck rise count
    task automatic wait_lv(input int s, input int b, input logic lv, output int r);
        for (int n = 0; sig(s, b) !== lv; n++) begin
            if (n == 4000) stop("output wait timeout");
            @(negedge pclk);
        end
        r = rises;
    endtask

    // reset values, unmapped access, latency read-back
    task automatic t_regs;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0, "ctrl reset");
        apb(1'b0, ADDR_LAT, 32'h0);
        chk(rd, 32'h0005_0006, "lat reset");
        apb(1'b0, ADDR_TCK, 32'h0);
        chk(rd, 32'h0000_09C4, "tck reset");
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], er}, 32'h1, "unmapped read");
        apb(1'b1, ADDR_LAT, 32'h0005_0206);
        apb(1'b0, ADDR_LAT, 32'h0);
        chk(rd, 32'h0005_0206, "lat readback");
    endtask

    // leveling feedback follows ck level at the strobe rise
    task automatic t_level;
        apb(1'b1, ADDR_CTRL, 32'h1);
        repeat (3) @(posedge pclk);
        chk(32'(dq0_oe), 32'h1, "feedback drive on");
        u_sdtr_ctrl_model.strobe(40, 1'b1);
        repeat (4) @(posedge pclk);
        chk(32'(dq0_o), 32'h1, "feedback ck high");
        u_sdtr_ctrl_model.strobe(0, 1'b0);
        repeat (4) @(posedge pclk);
        chk(32'(dq0_o), 32'h0, "feedback ck low");
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (3) @(posedge pclk);
        chk(32'(dq0_oe), 32'h0, "feedback drive off");
    endtask

    // read window start and length, delay loop on and off, chop on and off
    task automatic t_read;
        int s, r0, r1;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_CTRL, {30'h0, m[0], 1'b0});
            repeat (10) @(posedge ck); // locked exit delay after a mode change, before the read
            u_sdtr_ctrl_model.issue(SDTR_RD, 3'h1, m[1], s);
            u_sdtr_ctrl_model.idle();
            wait_lv(0, 0, 1'b1, r0);
            chk(32'(r0 - s), 32'(8 - m[0]), "window start");
            wait_lv(0, 0, 1'b0, r1);
            chk(32'(r1 - r0), m[1] ? 32'h2 : 32'h4, "window length");
        end
    endtask

    // recovery start: eight beats, on-the-fly chop, chop fixed by mode
    task automatic t_write;
        int s, r;
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, ADDR_CTRL, (m == 2) ? 32'h8 : 32'h0);
            u_sdtr_ctrl_model.issue(SDTR_WR, 3'h2, m == 1, s);
            u_sdtr_ctrl_model.idle();
            wait_lv(1, 0, 1'b1, r);
            chk(32'(r - s), (m == 2) ? 32'h7 : 32'h9, "recovery start");
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk(32'(rd[16]), 32'h1, "recovery busy after start");
        end
    endtask

    // read auto precharge right after activate waits out the row time, rounded up
    task automatic t_autopre;
        int a, s, r;
        apb(1'b1, ADDR_TCK, 32'h0000_0BB8); // new link period, elapsed row time accumulates by it
        u_sdtr_ctrl_model.issue(SDTR_ACT, 3'h3, 1'b0, a);
        u_sdtr_ctrl_model.issue(SDTR_RDA, 3'h3, 1'b0, s);
        u_sdtr_ctrl_model.idle();
        wait_lv(2, 3, 1'b1, r);
        chk(32'(r - a), 32'hC, "precharge hold-off");
        repeat (2) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({16'h0, rd[15:8], 4'h0, rd[3], 3'h0}, 32'h0, "bank closed");
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs();
        t_level();
        t_read();
        t_write();
        t_autopre();
        give_verdict();
    end
endmodule // sdtr_timing_tb_top
`default_nettype wire
